// >>> vic_defs.svh
// Constants for the vectored interrupt controller.
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
`define VIC_NSRC        18
`define VIC_IDXW        5
`define VIC_NPIN        3
`define VIC_OFF_REQ     8'h00
`define VIC_OFF_MASK    8'h04
`define VIC_OFF_PRIO    8'h08
`define VIC_OFF_EDGE    8'h0C
`define VIC_OFF_PSW     8'h10
`define VIC_OFF_STATUS  8'h14
`define VIC_RST_REQ     18'h00000
`define VIC_RST_MASK    18'h3FFFF
`define VIC_RST_PRIO    18'h3FFFF
`define VIC_RST_EDGE    3'h0
`define VIC_RST_PSW     8'h02
`define VIC_PSW_IE      7
`define VIC_PSW_ISP     1
`define VIC_EDGE_FALL   8
`define VIC_STAT_NMI    8
`define VIC_STAT_BRK    9
`define VIC_STAT_VALID  10
`define VIC_VEC_NMI     16'h0004
`define VIC_VEC_BASE    16'h0004
`define VIC_VEC_BRK     16'h003E
`define VIC_SRC_WDT     0
`define VIC_SRC_PIN0    4
`define VIC_SRC_TM16A   7
`define VIC_SRC_TM8A    9
`define VIC_SRC_WATCHI  11
`define VIC_SRC_SERERR  14
`endif

// >>> vic_pkg.sv
// Types shared by the vectored interrupt controller.
package vic_pkg;
  typedef enum logic [1:0] {
    KIND_MASKABLE = 2'b00,
    KIND_NMI      = 2'b01,
    KIND_BREAK    = 2'b10
  } kind_t;
  typedef struct packed {
    logic        valid;
    kind_t       kind;
    logic [15:0] vector;
  } core_req_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] word;
  } psw_xfer_t;
endpackage

// >>> vectored_interrupt_controller.sv
// Vectored interrupt controller with APB register access.
`timescale 1ns/1ns
`include "vic_defs.svh"

module vectored_interrupt_controller #(
  parameter int NSRC = `VIC_NSRC
) (
  // Clock, reset and enable.
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  input  wire logic               CE,
  // APB slave.
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // Request sources.
  input  wire logic               WDT_OVERFLOW,
  input  wire logic               WDT_NMI_MODE,
  input  wire logic [2:0]         EXT_PIN,
  input  wire logic [NSRC-1:0]    PERIPH_REQUEST,
  input  wire logic               SOFTWARE_BREAK_INSTRUCTION,
  // Core side.
  input  wire logic               INT_ACK,
  input  wire vic_pkg::psw_xfer_t PSW_RESTORE,
  output vic_pkg::core_req_t      CORE_REQ,
  output vic_pkg::psw_xfer_t      PSW_SAVE,
  output logic                    STANDBY_RELEASE
);

  logic [NSRC-1:0]          request_flag_reg;
  logic [NSRC-1:0]          request_flag_next;
  logic [NSRC-1:0]          mask_flag_reg;
  logic [NSRC-1:0]          priority_group_flag_reg;
  logic [`VIC_NPIN-1:0]     rising_edge_enable_reg;
  logic [`VIC_NPIN-1:0]     falling_edge_enable_reg;
  logic [`VIC_NPIN-1:0]     pin_prev_reg;
  logic [7:0]               status_word_reg;
  logic                     nmi_pend_reg;
  logic                     brk_pend_reg;
  logic [`VIC_IDXW-1:0]     win_idx_reg;
  logic [NSRC-1:0]          src_set;
  logic [NSRC-1:0]          eligible;
  logic [NSRC-1:0]          ack_clr;
  logic [`VIC_NPIN-1:0]     pin_edge;
  logic [`VIC_IDXW-1:0]     win_idx;
  logic                     win_any;
  logic                     global_interrupt_enable;
  logic                     in_service_priority_bit;
  logic                     acked;
  logic                     wr_en;
  logic                     rd_phase;
  logic                     mapped;
  logic [31:0]              rd_word;

  // Lowest set index of a vector, with a found flag in the top bit.
  function automatic logic [`VIC_IDXW:0] first_set(input logic [NSRC-1:0] v);
    logic [`VIC_IDXW:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[`VIC_IDXW-1:0]};
      end
    end
    return r;
  endfunction

  // Vector address of maskable source n, spaced by two bytes.
  function automatic logic [15:0] vector_of(input logic [`VIC_IDXW-1:0] n);
    return `VIC_VEC_BASE + {10'h000, n, 1'b0};
  endfunction

  assign global_interrupt_enable = status_word_reg[`VIC_PSW_IE];
  assign in_service_priority_bit = status_word_reg[`VIC_PSW_ISP];
  assign acked    = INT_ACK && CORE_REQ.valid;
  assign wr_en    = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_phase = PSEL && PENABLE && !PREADY;

  // Selected pin edges raise pin requests.
  assign pin_edge = (EXT_PIN & ~pin_prev_reg & rising_edge_enable_reg)
                  | (~EXT_PIN & pin_prev_reg & falling_edge_enable_reg);

  // Source events into request flags.
  always_comb begin
    src_set = PERIPH_REQUEST;
    src_set[`VIC_SRC_WDT] = WDT_OVERFLOW && !WDT_NMI_MODE;
    src_set[`VIC_SRC_PIN0 +: `VIC_NPIN] = pin_edge;
    src_set[`VIC_SRC_TM16A +: 2] = PERIPH_REQUEST[`VIC_SRC_TM16A +: 2];
    src_set[`VIC_SRC_TM8A +: 2] = PERIPH_REQUEST[`VIC_SRC_TM8A +: 2];
    src_set[`VIC_SRC_WATCHI +: 2] = PERIPH_REQUEST[`VIC_SRC_WATCHI +: 2];
    src_set[`VIC_SRC_SERERR +: 2] = PERIPH_REQUEST[`VIC_SRC_SERERR +: 2];
  end

  // Eligible maskable requests and the winner among them.
  always_comb begin
    eligible = request_flag_reg & ~mask_flag_reg;
    if (!global_interrupt_enable) begin
      eligible = '0;
    end else if (!in_service_priority_bit) begin
      eligible = eligible & ~priority_group_flag_reg;
    end
    if ((eligible & ~priority_group_flag_reg) != '0) begin
      eligible = eligible & ~priority_group_flag_reg;
    end
    {win_any, win_idx} = first_set(eligible);
  end

  always_comb begin
    ack_clr = '0;
    if (acked && CORE_REQ.kind == vic_pkg::KIND_MASKABLE) begin
      ack_clr[win_idx_reg] = 1'b1;
    end
  end

  // New events win over clears from software or acknowledge.
  always_comb begin
    request_flag_next = request_flag_reg & ~ack_clr;
    if (wr_en && PADDR == `VIC_OFF_REQ) begin
      request_flag_next = PWDATA[NSRC-1:0] & ~ack_clr;
    end
    request_flag_next = request_flag_next | src_set;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      request_flag_reg <= `VIC_RST_REQ;
      pin_prev_reg     <= `VIC_RST_EDGE;
    end else if (CE) begin
      request_flag_reg <= request_flag_next;
      pin_prev_reg     <= EXT_PIN;
    end
  end

  // Non-maskable and break pending flags.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      nmi_pend_reg <= 1'b0;
      brk_pend_reg <= 1'b0;
    end else if (CE) begin
      nmi_pend_reg <= (WDT_OVERFLOW && WDT_NMI_MODE)
                   || (nmi_pend_reg
                       && !(acked && CORE_REQ.kind == vic_pkg::KIND_NMI));
      brk_pend_reg <= SOFTWARE_BREAK_INSTRUCTION
                   || (brk_pend_reg
                       && !(acked && CORE_REQ.kind == vic_pkg::KIND_BREAK));
    end
  end

  // Mask, group and edge configuration.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_flag_reg           <= `VIC_RST_MASK;
      priority_group_flag_reg <= `VIC_RST_PRIO;
      rising_edge_enable_reg  <= `VIC_RST_EDGE;
      falling_edge_enable_reg <= `VIC_RST_EDGE;
    end else if (CE && wr_en) begin
      if (PADDR == `VIC_OFF_MASK) begin
        mask_flag_reg <= PWDATA[NSRC-1:0];
      end else if (PADDR == `VIC_OFF_PRIO) begin
        priority_group_flag_reg <= PWDATA[NSRC-1:0];
      end else if (PADDR == `VIC_OFF_EDGE) begin
        rising_edge_enable_reg  <= PWDATA[`VIC_NPIN-1:0];
        falling_edge_enable_reg <= PWDATA[`VIC_EDGE_FALL +: `VIC_NPIN];
      end
    end
  end

  // Status word: acknowledge, then core restore, then software write.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_word_reg <= `VIC_RST_PSW;
      PSW_SAVE        <= '0;
    end else if (CE) begin
      PSW_SAVE.valid <= acked;
      if (acked) begin
        PSW_SAVE.word <= status_word_reg;
        status_word_reg[`VIC_PSW_IE] <= 1'b0;
        if (CORE_REQ.kind == vic_pkg::KIND_MASKABLE) begin
          status_word_reg[`VIC_PSW_ISP] <=
            priority_group_flag_reg[win_idx_reg];
        end
      end else if (PSW_RESTORE.valid) begin
        status_word_reg <= PSW_RESTORE.word;
      end else if (wr_en && PADDR == `VIC_OFF_PSW) begin
        status_word_reg <= PWDATA[7:0];
      end
    end
  end

  // Request presented to the core.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_REQ        <= '0;
      win_idx_reg     <= '0;
      STANDBY_RELEASE <= 1'b0;
    end else if (CE) begin
      STANDBY_RELEASE <= nmi_pend_reg
                      || ((request_flag_reg & ~mask_flag_reg) != '0);
      CORE_REQ.valid  <= 1'b0;
      if (acked) begin
        CORE_REQ.valid <= 1'b0;
      end else if (nmi_pend_reg) begin
        CORE_REQ.valid  <= 1'b1;
        CORE_REQ.kind   <= vic_pkg::KIND_NMI;
        CORE_REQ.vector <= `VIC_VEC_NMI;
      end else if (brk_pend_reg) begin
        CORE_REQ.valid  <= 1'b1;
        CORE_REQ.kind   <= vic_pkg::KIND_BREAK;
        CORE_REQ.vector <= `VIC_VEC_BRK;
      end else if (win_any) begin
        CORE_REQ.valid  <= 1'b1;
        CORE_REQ.kind   <= vic_pkg::KIND_MASKABLE;
        CORE_REQ.vector <= vector_of(win_idx);
        win_idx_reg     <= win_idx;
      end
    end
  end

  // Read data decode.
  always_comb begin
    mapped  = 1'b1;
    rd_word = '0;
    if (PADDR == `VIC_OFF_REQ) begin
      rd_word[NSRC-1:0] = request_flag_reg;
    end else if (PADDR == `VIC_OFF_MASK) begin
      rd_word[NSRC-1:0] = mask_flag_reg;
    end else if (PADDR == `VIC_OFF_PRIO) begin
      rd_word[NSRC-1:0] = priority_group_flag_reg;
    end else if (PADDR == `VIC_OFF_EDGE) begin
      rd_word[`VIC_NPIN-1:0] = rising_edge_enable_reg;
      rd_word[`VIC_EDGE_FALL +: `VIC_NPIN] = falling_edge_enable_reg;
    end else if (PADDR == `VIC_OFF_PSW) begin
      rd_word[7:0] = status_word_reg;
    end else if (PADDR == `VIC_OFF_STATUS) begin
      rd_word[`VIC_IDXW-1:0] = win_idx_reg;
      rd_word[`VIC_STAT_NMI]   = nmi_pend_reg;
      rd_word[`VIC_STAT_BRK]   = brk_pend_reg;
      rd_word[`VIC_STAT_VALID] = CORE_REQ.valid;
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer: one wait cycle in every access phase.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= rd_phase;
      PSLVERR <= rd_phase && !mapped;
      if (rd_phase && !PWRITE) begin
        PRDATA <= rd_word;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_nmi_ranks_first: assert property (
    CE && nmi_pend_reg && !acked |=> CORE_REQ.valid
      && CORE_REQ.kind == vic_pkg::KIND_NMI)
    else $error("Pending non-maskable request not presented first.");

  a_nmi_wakes_core: assert property (
    CE && WDT_OVERFLOW && WDT_NMI_MODE ##1 CE |=> STANDBY_RELEASE)
    else $error("Non-maskable request did not release standby.");

  a_nmi_vector_fixed: assert property (
    CORE_REQ.valid && CORE_REQ.kind == vic_pkg::KIND_NMI
      |-> CORE_REQ.vector == `VIC_VEC_NMI)
    else $error("Non-maskable vector wrong.");

  a_wdt_interval_flag: assert property (
    CE && WDT_OVERFLOW && !WDT_NMI_MODE |=> request_flag_reg[`VIC_SRC_WDT])
    else $error("Interval watchdog overflow lost.");

  a_masked_stays_quiet: assert property (
    CE && (request_flag_reg & ~mask_flag_reg) == '0 && !nmi_pend_reg
      && !brk_pend_reg |=> !CORE_REQ.valid)
    else $error("Request presented with nothing eligible.");

  a_maskable_wakes: assert property (
    CE && (request_flag_reg & ~mask_flag_reg) != '0 |=> STANDBY_RELEASE)
    else $error("Unmasked request did not release standby.");

  a_break_pending: assert property (
    CE && SOFTWARE_BREAK_INSTRUCTION |=> brk_pend_reg)
    else $error("Software break not held pending.");

  a_break_vector: assert property (
    CE && brk_pend_reg && !nmi_pend_reg && !acked |=> CORE_REQ.valid
      && CORE_REQ.kind == vic_pkg::KIND_BREAK
      && CORE_REQ.vector == `VIC_VEC_BRK)
    else $error("Software break not vectored.");

  a_ack_clears_enable: assert property (
    CE && acked |=> !status_word_reg[`VIC_PSW_IE] && PSW_SAVE.valid
      && PSW_SAVE.word == $past(status_word_reg))
    else $error("Acknowledge did not save status and clear enable.");

  a_lowest_wins: assert property (
    CE && win_any && !nmi_pend_reg && !brk_pend_reg && !acked
      |=> CORE_REQ.kind == vic_pkg::KIND_MASKABLE
      && CORE_REQ.vector - `VIC_VEC_BASE == 16'($past(win_idx)) * 16'h0002)
    else $error("Winning maskable vector wrong.");

  a_lowest_first: assert property (
    CE && win_any |-> (request_flag_reg & ~mask_flag_reg
      & ~({NSRC{1'b1}} << win_idx)
      & (priority_group_flag_reg[win_idx] ? priority_group_flag_reg
                                          : ~priority_group_flag_reg)) == '0)
    else $error("Lower numbered request of the winning group skipped.");

  a_high_group_only: assert property (
    CE && win_any && !in_service_priority_bit
      |-> !priority_group_flag_reg[win_idx])
    else $error("Low group request nested over a high group service.");

  a_ce_freeze: assert property (
    !CE |=> $stable(request_flag_reg) && $stable(status_word_reg)
      && $stable(CORE_REQ))
    else $error("State changed while the clock enable was low.");

  a_apb_one_wait: assert property (
    CE && PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("APB answer not given after one wait.");

endmodule

// >>> vic_core_model.sv
// Behavioural core that acknowledges requests and restores the status word.
`timescale 1ns/1ns
module vic_core_model (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Controller side.
  input  wire vic_pkg::core_req_t core_req,
  input  wire vic_pkg::psw_xfer_t psw_save,
  output vic_pkg::psw_xfer_t      psw_restore,
  output logic                    int_ack,
  // Bench side.
  input  wire logic [3:0]         ack_delay,
  input  wire logic               do_return,
  output logic [7:0]              ack_count,
  output logic [15:0]             last_vec,
  output vic_pkg::kind_t          last_kind,
  output logic [7:0]              saved_word
);
  logic [3:0] wait_cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      ack_count <= 8'h00;
      last_vec  <= 16'h0000;
      last_kind <= vic_pkg::KIND_MASKABLE;
    end else if (int_ack) begin
      int_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (core_req.valid && wait_cnt >= ack_delay) begin
      int_ack   <= 1'b1;
      last_vec  <= core_req.vector;
      last_kind <= core_req.kind;
      ack_count <= ack_count + 8'h01;
    end else if (core_req.valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      psw_restore <= '0;
      saved_word  <= 8'h00;
    end else begin
      if (psw_save.valid) begin
        saved_word <= psw_save.word;
      end
      psw_restore.valid <= do_return;
      psw_restore.word  <= do_return ? saved_word : ~saved_word;
    end
  end
endmodule

// >>> test_vectored_interrupt_controller.sv
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ns
`include "vic_defs.svh"
module test_vectored_interrupt_controller;
  logic               clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr, ack_count, saved_word;
  logic [31:0]        pwdata, prdata, rd;
  logic               wdt_ovf, wdt_nmi, software_break_instruction, int_ack, standby, do_return;
  logic               err, ce;
  logic [2:0]         ext_pin;
  logic [17:0]        periph;
  logic [3:0]         ack_delay;
  logic [15:0]        last_vec;
  vic_pkg::kind_t     last_kind;
  vic_pkg::core_req_t core_req;
  vic_pkg::psw_xfer_t psw_save, psw_restore;
  int                 fail_count, total_checks, cycles, n, p, m;

  vectored_interrupt_controller dut (
    .CLK(clk), .ARST_N(arst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WDT_OVERFLOW(wdt_ovf),
    .WDT_NMI_MODE(wdt_nmi), .EXT_PIN(ext_pin), .PERIPH_REQUEST(periph),
    .SOFTWARE_BREAK_INSTRUCTION(software_break_instruction), .INT_ACK(int_ack),
    .PSW_RESTORE(psw_restore), .CORE_REQ(core_req), .PSW_SAVE(psw_save),
    .STANDBY_RELEASE(standby));

  vic_core_model core (
    .clk(clk), .arst_n(arst_n), .core_req(core_req), .psw_save(psw_save),
    .psw_restore(psw_restore), .int_ack(int_ack), .ack_delay(ack_delay),
    .do_return(do_return), .ack_count(ack_count), .last_vec(last_vec),
    .last_kind(last_kind), .saved_word(saved_word));

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic fire(input logic [19:0] ev);
    periph  <= ev[17:0];
    wdt_ovf <= ev[18];
    software_break_instruction     <= ev[19];
    @(posedge clk);
    periph  <= 18'h00000;
    wdt_ovf <= 1'b0;
    software_break_instruction     <= 1'b0;
    @(posedge clk);
  endtask

  task automatic expect_irq(input logic hit, input logic [15:0] vec,
                            input vic_pkg::kind_t k);
    logic [7:0] c0;
    int         t;
    c0 = ack_count;
    t = 0;
    while (ack_count === c0 && t < 30) begin
      @(posedge clk);
      t++;
    end
    check({31'h0, ack_count !== c0}, {31'h0, hit});
    if (hit) begin
      check({16'h0, last_vec}, {16'h0, vec});
      check({30'h0, last_kind}, {30'h0, k});
    end
    repeat (3) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 20000) begin
        fail_count++;
        test_done();
      end
    end
  end

  initial begin
    {arst_n, psel, penable, pwrite, wdt_ovf, wdt_nmi, software_break_instruction, do_return} = '0;
    {paddr, pwdata, ext_pin, periph, ack_delay} = '0;
    ce = 1'b1;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk(`VIC_OFF_REQ, 32'h0);
    rchk(`VIC_OFF_MASK, 32'h3FFFF);
    rchk(`VIC_OFF_PRIO, 32'h3FFFF);
    rchk(`VIC_OFF_EDGE, 32'h0);
    rchk(`VIC_OFF_PSW, 32'h02);
    rchk(8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    ce <= 1'b0;
    fire(20'h00200);
    ce <= 1'b1;
    rchk(`VIC_OFF_REQ, 32'h0);
    apb(1'b1, `VIC_OFF_MASK, 32'h0);
    for (n = 1; n < 18; n++) begin
      if (n < 4 || n > 6) begin
        apb(1'b1, `VIC_OFF_PSW, 32'h82);
        fire(20'h1 << n);
        expect_irq(1'b1, 16'h0004 + 16'(2 * n), vic_pkg::KIND_MASKABLE);
        check({24'h0, saved_word}, 32'h82);
        rchk(`VIC_OFF_PSW, 32'h02);
        rchk(`VIC_OFF_REQ, 32'h0);
      end
    end
    apb(1'b1, `VIC_OFF_PSW, 32'h00);
    fire(20'h01200);
    expect_irq(1'b0, 16'h0, vic_pkg::KIND_MASKABLE);
    check({31'h0, standby}, 32'h1);
    rchk(`VIC_OFF_REQ, 32'h01200);
    apb(1'b1, `VIC_OFF_PSW, 32'h82);
    expect_irq(1'b1, 16'h0016, vic_pkg::KIND_MASKABLE);
    apb(1'b1, `VIC_OFF_PSW, 32'h82);
    expect_irq(1'b1, 16'h001C, vic_pkg::KIND_MASKABLE);
    apb(1'b1, `VIC_OFF_PRIO, 32'h3FDFF);
    apb(1'b1, `VIC_OFF_PSW, 32'h80);
    fire(20'h01000);
    expect_irq(1'b0, 16'h0, vic_pkg::KIND_MASKABLE);
    fire(20'h00200);
    expect_irq(1'b1, 16'h0016, vic_pkg::KIND_MASKABLE);
    rchk(`VIC_OFF_PSW, 32'h00);
    apb(1'b1, `VIC_OFF_REQ, 32'h0);
    apb(1'b1, `VIC_OFF_PRIO, 32'h3FFFF);
    wdt_nmi   <= 1'b1;
    ack_delay <= 4'h8;
    fire(20'hC0000);
    @(posedge clk);
    check({31'h0, standby}, 32'h1);
    expect_irq(1'b1, 16'h0004, vic_pkg::KIND_NMI);
    expect_irq(1'b1, 16'h003E, vic_pkg::KIND_BREAK);
    wdt_nmi   <= 1'b0;
    ack_delay <= 4'h0;
    apb(1'b1, `VIC_OFF_PSW, 32'h82);
    fire(20'h40000);
    expect_irq(1'b1, 16'h0004, vic_pkg::KIND_MASKABLE);
    do_return <= 1'b1;
    @(posedge clk);
    do_return <= 1'b0;
    @(posedge clk);
    rchk(`VIC_OFF_PSW, 32'h82);
    apb(1'b1, `VIC_OFF_MASK, 32'h08000);
    fire(20'h08000);
    expect_irq(1'b0, 16'h0, vic_pkg::KIND_MASKABLE);
    check({31'h0, standby}, 32'h0);
    apb(1'b1, `VIC_OFF_MASK, 32'h0);
    expect_irq(1'b1, 16'h0022, vic_pkg::KIND_MASKABLE);
    for (n = 0; n < 9; n++) begin
      p = n % 3;
      m = n / 3 + 1;
      apb(1'b1, `VIC_OFF_EDGE, (m[0] ? 32'h1 << p : 32'h0)
                             | (m[1] ? 32'h100 << p : 32'h0));
      apb(1'b1, `VIC_OFF_PSW, 32'h82);
      ext_pin[p] <= 1'b1;
      expect_irq(m[0], 16'h000C + 16'(2 * p), vic_pkg::KIND_MASKABLE);
      apb(1'b1, `VIC_OFF_PSW, 32'h82);
      ext_pin[p] <= 1'b0;
      expect_irq(m[1], 16'h000C + 16'(2 * p), vic_pkg::KIND_MASKABLE);
    end
    test_done();
  end
endmodule
